// ===== verilog/pc_stack_map.vh
// constants for the program counter, return stack and indirect addressing block
// assumes inclusion by bare name from the design file
`ifndef PC_STACK_MAP_VH
`define PC_STACK_MAP_VH
`define PC_WIDTH        13
`define PC_LOW_WIDTH    8
`define PC_UPPER_WIDTH  5
`define BRANCH_WIDTH    11
`define PAGE_SEL_HI     4
`define PAGE_SEL_LO     3
`define STACK_DEPTH     8
`define STACK_PTR_WIDTH 3
`define IND_ADDR_WIDTH  9
`define INDIRECT_PORT_ADDR 8'h00
`define PC_RESET        13'h0000
`define PC_LOW_RESET    8'h00
`define PC_UPPER_RESET  5'h00
`define LATCH_RESET     8'h00
`define FSR_RESET       8'h00
`endif

// ===== verilog/pc_stack_indirect.v
// program counter sequencing, circular return stack and indirect address forming
// assumes the execution logic presents one decoded action per clock, single clock
// stack contents are not reset; software never sees the stack pointer
`timescale 1ns/10ps
`include "pc_stack_map.vh"

// Behaviour
// - 13-bit counter, low byte read and write
// - upper counter bits not directly writable
// - any reset clears upper counter bits
// - low byte write loads latch bits 4:0
// - branch takes 11 bits, page from latch
// - eight entry, 13-bit return stack
// - stack pointer hidden from software
// - push on call and interrupt vector
// - returns pop full counter from stack
// - stack activity leaves high latch alone
// - ninth push overwrites first entry
// - no overflow or underflow indication
// - 8K word space in 2K pages
// - indirect port accesses pointed register
// - indirect read of port returns zero
// - indirect write of port does nothing
// - bank bit above pointer forms address
module pc_stack_indirect #(
    parameter STACK_DEPTH = `STACK_DEPTH
) (
    // clock and reset
    input  wire                        clk_i,
    input  wire                        rstn_i,
    // sequencing controls from execution logic
    input  wire                        advance_i,
    input  wire                        low_byte_wr_i,
    input  wire [7:0]                  low_byte_wdata_i,
    input  wire                        call_i,
    input  wire                        jump_i,
    input  wire [`BRANCH_WIDTH-1:0]    branch_addr_i,
    input  wire                        vector_i,
    input  wire [`PC_WIDTH-1:0]        vector_addr_i,
    input  wire                        return_i,
    // high latch write
    input  wire                        latch_wr_i,
    input  wire [7:0]                  latch_wdata_i,
    // indirect addressing
    input  wire                        fsr_wr_i,
    input  wire [7:0]                  fsr_wdata_i,
    input  wire                        indirect_bank_bit_i,
    input  wire                        file_access_i,
    input  wire                        file_write_i,
    input  wire [6:0]                  file_addr_i,
    input  wire [7:0]                  file_rdata_i,
    // counter outputs
    output wire [`PC_WIDTH-1:0]        pc_o,
    output wire [7:0]                  pc_low_byte_o,
    output wire [7:0]                  pc_high_latch_o,
    // indirect outputs
    output wire [7:0]                  file_pointer_reg_o,
    output reg  [`IND_ADDR_WIDTH-1:0]  eff_addr_o,
    output reg                         eff_is_indirect_o,
    output reg                         eff_write_en_o,
    output reg  [7:0]                  indirect_rdata_o
);

    // counter state
    reg  [`PC_LOW_WIDTH-1:0]      pc_low_byte_r;
    reg  [`PC_LOW_WIDTH-1:0]      pc_low_byte_nxt;
    reg  [`PC_UPPER_WIDTH-1:0]    pc_upper_bits_r;
    reg  [`PC_UPPER_WIDTH-1:0]    pc_upper_bits_nxt;
    reg  [`PC_WIDTH-1:0]          pc_load;

    // software visible registers
    reg  [7:0]                    pc_high_latch_r;
    reg  [7:0]                    pc_high_latch_nxt;
    reg  [7:0]                    file_pointer_reg_r;
    reg  [7:0]                    file_pointer_reg_nxt;

    reg  [`STACK_PTR_WIDTH-1:0]   sp_r;
    reg  [`STACK_PTR_WIDTH-1:0]   sp_nxt;
    reg  [`PC_WIDTH-1:0]          stack_mem [0:STACK_DEPTH-1];
    reg                           stack_we;
    reg  [`PC_WIDTH-1:0]          stack_wdata;

    // derived values
    wire [`PC_WIDTH-1:0]          pc_cur;
    wire [`PC_WIDTH-1:0]          pc_inc;
    wire [`PC_WIDTH-1:0]          page_target;
    wire [`PC_WIDTH-1:0]          latch_target;
    wire [`STACK_PTR_WIDTH-1:0]   sp_push;
    wire [`STACK_PTR_WIDTH-1:0]   sp_pop;
    wire [`PC_WIDTH-1:0]          ret_addr;

    // one-hot action decode
    wire                          act_return;
    wire                          act_vector;
    wire                          act_branch;
    wire                          act_low_wr;
    wire                          act_advance;
    wire                          any_branch;
    wire                          above_branch;
    wire                          above_low_wr;
    wire                          above_advance;
    wire                          do_push;
    wire                          do_pop;

    // indirect decode
    wire                          is_indirect;
    wire                          self_pointer;

    // port address test, used for both the direct and the pointed address
    function is_port_addr;
        input [7:0] addr;
        begin
            is_port_addr = (addr == `INDIRECT_PORT_ADDR);
        end
    endfunction

    // pointer step with wrap, shared by push and pop
    function [`STACK_PTR_WIDTH-1:0] ptr_step;
        input [`STACK_PTR_WIDTH-1:0] ptr;
        input                        up;
        begin
            if (up) begin
                ptr_step = ptr + 3'h1;
            end else begin
                ptr_step = ptr - 3'h1;
            end
        end
    endfunction

    // counter built from an upper part and a lower part
    function [`PC_WIDTH-1:0] join_pc;
        input [`PC_UPPER_WIDTH-1:0] upper;
        input [`PC_LOW_WIDTH-1:0]   lower;
        begin
            join_pc = {upper, lower};
        end
    endfunction

    // priority: return, vector, branch, low byte write, advance
    assign any_branch    = call_i | jump_i;
    // each level is blocked by everything above it
    assign above_branch  = return_i | vector_i;
    assign above_low_wr  = above_branch | any_branch;
    assign above_advance = above_low_wr | low_byte_wr_i;
    assign act_return    = return_i;
    assign act_vector    = vector_i & ~return_i;
    assign act_branch    = any_branch & ~above_branch;
    assign act_low_wr    = low_byte_wr_i & ~above_low_wr;
    assign act_advance   = advance_i & ~above_advance;

    // push on call or vector
    // a return in the same cycle wins, so the pointer holds and nothing is pushed
    assign do_push = (call_i | vector_i) & ~return_i;
    assign do_pop  = return_i & ~call_i & ~vector_i;

    assign pc_cur       = join_pc(pc_upper_bits_r, pc_low_byte_r);
    assign pc_inc       = pc_cur + 13'h0001;
    assign page_target  = join_pc({pc_high_latch_r[`PAGE_SEL_HI:`PAGE_SEL_LO],
                                   branch_addr_i[`BRANCH_WIDTH-1:`PC_LOW_WIDTH]},
                                  branch_addr_i[`PC_LOW_WIDTH-1:0]);
    assign latch_target = join_pc(pc_high_latch_r[`PC_UPPER_WIDTH-1:0], low_byte_wdata_i);

    assign sp_pop   = ptr_step(sp_r, 1'b0);
    // push wraps too, no full check
    assign sp_push  = ptr_step(sp_r, 1'b1);
    // pop reads the slot below the pointer, the last one pushed
    assign ret_addr = stack_mem[sp_pop];

    always @* begin
        pc_load = pc_cur;
        case (1'b1)
            act_return: begin
                pc_load = ret_addr;
            end
            act_vector: begin
                pc_load = vector_addr_i;
            end
            act_branch: begin
                pc_load = page_target;
            end
            act_low_wr: begin
                pc_load = latch_target;
            end
            act_advance: begin
                pc_load = pc_inc;
            end
            // held when idle, so a stalled core keeps its place
            default: begin
                pc_load = pc_cur;
            end
        endcase
        pc_low_byte_nxt   = pc_load[`PC_LOW_WIDTH-1:0];
        pc_upper_bits_nxt = pc_load[`PC_WIDTH-1:`PC_LOW_WIDTH];
    end

    always @* begin
        sp_nxt = sp_r;
        case ({do_push, do_pop})
            2'b10: begin
                sp_nxt = sp_push;
            end
            // pop from empty still wraps
            // no underflow guard: an empty pop lands on slot seven
            2'b01: begin
                sp_nxt = sp_pop;
            end
            default: begin
                sp_nxt = sp_r;
            end
        endcase
    end

    // latch changes only on its own write
    always @* begin
        pc_high_latch_nxt = pc_high_latch_r;
        if (latch_wr_i) begin
            pc_high_latch_nxt = latch_wdata_i;
        end
    end

    // pointer write is independent of counter actions
    always @* begin
        file_pointer_reg_nxt = file_pointer_reg_r;
        if (fsr_wr_i) begin
            file_pointer_reg_nxt = fsr_wdata_i;
        end
    end

    // return address is the next instruction, never the call itself
    always @* begin
        stack_we    = 1'b0;
        stack_wdata = pc_inc;
        if (rstn_i && do_push) begin
            stack_we = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_upper_bits_r <= `PC_UPPER_RESET;
        end else begin
            pc_upper_bits_r <= pc_upper_bits_nxt;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_low_byte_r <= `PC_LOW_RESET;
        end else begin
            pc_low_byte_r <= pc_low_byte_nxt;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            sp_r <= {`STACK_PTR_WIDTH{1'b0}};
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // stack storage, no reset needed
    // contents survive reset on purpose: only the pointer is cleared
    always @(posedge clk_i) begin
        if (stack_we) begin
            stack_mem[sp_r] <= stack_wdata;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_high_latch_r <= `LATCH_RESET;
        end else begin
            pc_high_latch_r <= pc_high_latch_nxt;
        end
    end

    // pointer and latch reset together with the counter
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            file_pointer_reg_r <= `FSR_RESET;
        end else begin
            file_pointer_reg_r <= file_pointer_reg_nxt;
        end
    end

    // port address redirects access
    // direct address is seven bits, so widen before the port test
    assign is_indirect  = file_access_i & is_port_addr({1'b0, file_addr_i});
    assign self_pointer = is_port_addr(file_pointer_reg_r);

    always @* begin
        eff_addr_o = {2'h0, file_addr_i};
        if (is_indirect) begin
            eff_addr_o = {indirect_bank_bit_i, file_pointer_reg_r};
        end
    end

    always @* begin
        indirect_rdata_o = file_rdata_i;
        if (is_indirect && self_pointer) begin
            indirect_rdata_o = 8'h00;
        end
    end

    // self write suppressed
    // flags elsewhere may still update, only the store is dropped
    always @* begin
        eff_write_en_o = file_access_i & file_write_i;
        if (is_indirect && self_pointer) begin
            eff_write_en_o = 1'b0;
        end
    end

    always @* begin
        eff_is_indirect_o = is_indirect;
    end

    assign pc_o               = pc_cur;
    assign pc_low_byte_o      = pc_low_byte_r;
    assign pc_high_latch_o    = pc_high_latch_r;
    assign file_pointer_reg_o = file_pointer_reg_r;

endmodule // pc_stack_indirect

// ===== sim/file_mem_model.sv
// data memory model answering reads at the effective address
// assumes a combinational read whose data is a fixed function of address
`timescale 1ns/10ps
module file_mem_model (
    input  wire [8:0] addr_i,
    output wire [7:0] rdata_o
);
    // pattern differs per bank so a lost bank bit shows up as wrong data
    assign rdata_o = addr_i[7:0] ^ {addr_i[8], 7'h2A};
endmodule // file_mem_model

// ===== sim/pc_checker_assertions.sv
// assertions on counter loads, stack returns and indirect addressing
// assumes binding onto pc_stack_indirect, one clock domain
`timescale 1ns/10ps
module pc_checker (
    input wire clk_i, rstn_i, low_byte_wr_i, call_i, jump_i, vector_i, return_i,
    input wire latch_wr_i, indirect_bank_bit_i, file_access_i, eff_is_indirect_o, eff_write_en_o,
    input wire [7:0] low_byte_wdata_i, file_rdata_i, pc_low_byte_o, pc_high_latch_o,
    input wire [7:0] file_pointer_reg_o, indirect_rdata_o, input wire [6:0] file_addr_i,
    input wire [10:0] branch_addr_i, input wire [12:0] vector_addr_i, pc_o,
    input wire [8:0] eff_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire hi = return_i | vector_i;
    wire ind = file_access_i && file_addr_i == 7'h00;
    sequence call_s; call_i && !hi; endsequence
    sequence ret_s; return_i; endsequence
    reset_clear_a: assert property (disable iff (1'b0) !rstn_i |=> pc_o[12:8] == 5'h00)
        else $error("upper bits not cleared");
    low_load_a: assert property (low_byte_wr_i && !hi && !call_i && !jump_i |=>
        pc_o == {$past(pc_high_latch_o[4:0]), $past(low_byte_wdata_i)} && pc_low_byte_o == pc_o[7:0])
        else $error("low byte write load wrong");
    branch_page_a: assert property ((jump_i || call_i) && !hi |=>
        pc_o == {$past(pc_high_latch_o[4:3]), $past(branch_addr_i)}) else $error("branch target wrong");
    call_ret_a: assert property (call_s ##1 ret_s |=> pc_o == $past(pc_o, 2) + 13'h1)
        else $error("return address wrong");
    vector_a: assert property (vector_i && !return_i |=> pc_o == $past(vector_addr_i))
        else $error("vector load wrong");
    latch_keep_a: assert property ((hi || call_i) && !latch_wr_i |=> $stable(pc_high_latch_o))
        else $error("latch changed by stack");
    port_zero_a: assert property (ind && file_pointer_reg_o == 8'h00 |->
        indirect_rdata_o == 8'h00 && !eff_write_en_o) else $error("self pointer access wrong");
    ind_addr_a: assert property (ind |-> eff_is_indirect_o &&
        eff_addr_o == {indirect_bank_bit_i, file_pointer_reg_o}) else $error("indirect address wrong");
    direct_addr_a: assert property (file_access_i && file_addr_i != 7'h00 |-> !eff_is_indirect_o &&
        eff_addr_o == {2'b00, file_addr_i} && indirect_rdata_o == file_rdata_i) else $error("direct wrong");
endmodule // pc_checker
bind pc_stack_indirect pc_checker chk_u (.*);

// ===== sim/testbench.sv
// self-checking bench: directed stack wrap and random sequencing against a reference model
// assumes design, checker bind and memory model compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
    reg clk_i = 1'b0, rstn_i = 1'b0, advance_i = 1'b0, low_byte_wr_i = 1'b0, call_i = 1'b0;
    reg jump_i = 1'b0, vector_i = 1'b0, return_i = 1'b0, latch_wr_i = 1'b0, fsr_wr_i = 1'b0;
    reg indirect_bank_bit_i = 1'b0, file_access_i = 1'b0, file_write_i = 1'b0;
    reg [7:0] low_byte_wdata_i = 8'h00, latch_wdata_i = 8'h00, fsr_wdata_i = 8'h00;
    reg [10:0] branch_addr_i = 11'h000;
    reg [12:0] vector_addr_i = 13'h0000;
    reg [6:0] file_addr_i = 7'h00;
    wire [7:0] file_rdata_i, pc_low_byte_o, pc_high_latch_o, file_pointer_reg_o, indirect_rdata_o;
    wire [12:0] pc_o;
    wire [8:0] eff_addr_o;
    wire eff_is_indirect_o, eff_write_en_o;
    wire [36:0] got_seq = {pc_low_byte_o, pc_high_latch_o, file_pointer_reg_o, pc_o};
    wire [18:0] got_ind = {eff_addr_o, eff_is_indirect_o, eff_write_en_o, indirect_rdata_o};
    reg [12:0] pc, stk [0:7];
    reg [7:0] lat, file_pointer_reg;
    reg [2:0] sp;
    reg [36:0] prev;
    reg [55:0] exp_v, q [$];
    reg have = 1'b0;
    int seed = 48, n_mismatch = 0, num_checks = 0, i;
    pc_stack_indirect dut_u (.*);
    file_mem_model mem_u (.addr_i(eff_addr_o), .rdata_o(file_rdata_i));
    initial forever #25 clk_i = ~clk_i;
    always @(negedge clk_i) if (q.size() > 0) begin
        exp_v = q.pop_front();
        `CHK(got_seq, exp_v[55:19])
        `CHK(got_ind, exp_v[18:0])
    end
    // one action per call; expectation queued when the design has taken it
    task op(input int k); reg [31:0] d; reg [6:0] fa; reg [8:0] ea; reg slf; begin
        d = $random(seed);
        @(posedge clk_i);
        // pointed address uses the pointer as it stands before this cycle's write
        fa = d[24] ? 7'h00 : d[30:24];
        ea = (fa == 7'h00) ? {d[31], file_pointer_reg} : {2'b00, fa};
        // self pointer reads zero and stores nothing
        slf = (fa == 7'h00) && (file_pointer_reg == 8'h00);
        if (have) q.push_back({prev, ea, fa == 7'h00, d[23] && !slf,
            slf ? 8'h00 : ea[7:0] ^ {ea[8], 7'h2A}});
        rstn_i <= k != 8; advance_i <= k == 0; low_byte_wr_i <= k == 1; jump_i <= k == 2;
        call_i <= k == 3; vector_i <= k == 4; return_i <= k == 5; latch_wr_i <= k == 6;
        low_byte_wdata_i <= d[7:0]; latch_wdata_i <= d[7:0]; branch_addr_i <= d[10:0];
        vector_addr_i <= d[12:0]; fsr_wr_i <= d[13]; fsr_wdata_i <= d[22] ? 8'h00 : d[21:14];
        file_access_i <= 1'b1; file_write_i <= d[23]; file_addr_i <= d[24] ? 7'h00 : d[30:24];
        indirect_bank_bit_i <= d[31];
        if (k == 3 || k == 4) begin stk[sp] = pc + 13'h1; sp = sp + 3'h1; end
        if (k == 5) sp = sp - 3'h1;
        if (d[13]) file_pointer_reg = d[22] ? 8'h00 : d[21:14];
        case (k)
            0: pc = pc + 13'h1;
            // computed jumps stay inside the latched page
            1: pc = {lat[4:0], d[7:0]};
            2, 3: pc = {lat[4:3], d[10:0]};
            4: pc = d[12:0];
            5: pc = stk[sp];
            6: lat = d[7:0];
            8: begin pc = 13'h0000; lat = 8'h00; file_pointer_reg = 8'h00; sp = 3'h0; end
        endcase
        prev = {pc[7:0], lat, file_pointer_reg, pc};
        have = 1'b1;
    end endtask
    task end_of_test; begin
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    initial begin
        pc = 13'h0000; lat = 8'h00; file_pointer_reg = 8'h00; sp = 3'h0;
        repeat (4) @(posedge clk_i);
        op(7);
        op(6);
        for (i = 0; i < 9; i++) op(3);
        // pops run past the wrapped entries
        for (i = 0; i < 10; i++) op(5);
        // random mix includes mid-run resets and back-to-back calls and returns
        for (i = 0; i < 400; i++) op({$random(seed)} % 9);
        op(7);
        op(7);
        repeat (2) @(posedge clk_i);
        end_of_test();
    end
endmodule // testbench
